// ### hdl/exec_ops.sv
// execution datapath for subtract, xor, nibble swap, direction load and sleep
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1 - literal minus accumulator, result written to accumulator
// RQ2 - literal subtract: carry set when acc <= literal, digit carry on low nibble
// RQ3 - file register minus accumulator, result routed by destination bit
// RQ4 - register subtract: carry when acc <= operand, digit carry low nibble, zero
// RQ5 - subtract with borrow: register minus acc minus inverted carry, all flags
// RQ6 - destination bit 0 goes to accumulator, 1 back to file register
// RQ7 - sleep clears watchdog and prescaler, sets timeout, clears powerdown
// RQ8 - after those updates the core enters sleep with oscillator halted
// RQ9 - nibble swap exchanges halves of register, no flags change
// RQ10 - direction load copies acc to port a, b or c for operand 5, 6, 7
// RQ11 - literal xor with accumulator into accumulator, zero flag only
// RQ12 - register xor with accumulator, routed by destination, zero flag only
// RQ13 - zero flag set when the 8-bit result is zero, else cleared
module exec_ops #(
  parameter int WDT_PRESCALE_W = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic exec_i,
  input wire exec_ops_pkg::op_type op_i,
  input wire logic [7:0] literal_i,
  input wire logic [exec_ops_pkg::FILE_ADDR_W-1:0] file_addr_i,
  input wire logic dest_i,
  input wire logic [7:0] file_data_i,
  input wire logic wake_i,
  output logic [7:0] acc_o,
  output logic carry_flag_o,
  output logic digit_carry_flag_o,
  output logic zero_flag_o,
  output logic timeout_status_flag_o,
  output logic powerdown_status_flag_o,
  output logic file_we_o,
  output logic [exec_ops_pkg::FILE_ADDR_W-1:0] file_waddr_o,
  output logic [7:0] file_wdata_o,
  output logic [7:0] port_a_direction_o,
  output logic [7:0] port_b_direction_o,
  output logic [7:0] port_c_direction_o,
  output logic sleep_o,
  output logic osc_halt_o,
  output logic [7:0] watchdog_counter_o
);
  import exec_ops_pkg::*;
  logic [7:0] acc_ff;
  logic carry_ff;
  logic digit_carry_ff;
  logic zero_ff;
  logic timeout_ff;
  logic powerdown_ff;
  logic file_we_ff;
  logic [FILE_ADDR_W-1:0] file_waddr_ff;
  logic [7:0] file_wdata_ff;
  logic [7:0] dir_ff [DIR_PORT_COUNT];
  logic sleep_ff;

  // operand selection
  wire is_lit_sub = exec_i && (op_i == OP_LITERAL_MINUS_ACC);
  wire is_reg_sub = exec_i && (op_i == OP_REG_MINUS_ACC);
  wire is_sub_b = exec_i && (op_i == OP_REG_MINUS_ACC_BORROW);
  wire is_swap = exec_i && (op_i == OP_NIBBLE_SWAP);
  wire is_dir = exec_i && (op_i == OP_DIRECTION_LOAD);
  wire is_lit_xor = exec_i && (op_i == OP_LITERAL_XOR);
  wire is_reg_xor = exec_i && (op_i == OP_REGISTER_XOR);
  wire is_sleep = exec_i && (op_i == OP_SLEEP) && !sleep_ff;
  wire is_sub = is_lit_sub || is_reg_sub || is_sub_b;
  wire uses_dest = is_reg_sub || is_sub_b || is_swap || is_reg_xor;
  wire [7:0] minuend = is_lit_sub ? literal_i : file_data_i; // [RQ1] [RQ3]
  // borrow is the inverse of carry; plain subtracts act as carry = 1
  wire carry_in = is_sub_b ? carry_ff : 1'b1; // [RQ5]
  // a + ~b + cin gives a - b - !cin; carry out is the no-borrow flag
  wire [8:0] sub_sum = {1'b0, minuend} + {1'b0, ~acc_ff} + {8'h00, carry_in}; // [RQ1] [RQ3] [RQ5]
  wire [4:0] sub_low = {1'b0, minuend[3:0]} + {1'b0, ~acc_ff[3:0]} + {4'h0, carry_in};
  wire [7:0] swap_res = {file_data_i[3:0], file_data_i[7:4]}; // [RQ9]
  wire [7:0] xor_op = is_lit_xor ? literal_i : file_data_i;
  wire [7:0] xor_res = acc_ff ^ xor_op; // [RQ11] [RQ12]
  wire [7:0] result = is_sub ? sub_sum[7:0] : (is_swap ? swap_res : xor_res);
  wire updates_zero = is_sub || is_lit_xor || is_reg_xor;
  wire to_file = uses_dest && (dest_i == DEST_FILE); // [RQ6]
  wire to_acc = is_lit_sub || is_lit_xor || (uses_dest && (dest_i == DEST_ACC)); // [RQ6]
  wire [2:0] dir_sel = file_addr_i[2:0];
  wire dir_addr_ok = (file_addr_i[FILE_ADDR_W-1:3] == '0) && (dir_sel >= DIR_SEL_PORT_A);

  // refused at elaboration: the counter serves one to eight prescaler bits only
  if (WDT_PRESCALE_W < 1 || WDT_PRESCALE_W > 8) begin : g_bad_prescale
    $error("prescaler width out of range");
  end

  watchdog_counter #(
    .PRESCALE_W(WDT_PRESCALE_W)
  ) u_wdt (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(!sleep_ff),
    .clear_i(is_sleep), // [RQ7]
    .count_o(watchdog_counter_o),
    .prescale_o()
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_ff <= ACC_RESET;
    end else if (to_acc) begin
      acc_ff <= result; // [RQ1] [RQ11]
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      carry_ff <= 1'b0;
      digit_carry_ff <= 1'b0;
    end else if (is_sub) begin
      carry_ff <= sub_sum[8]; // [RQ2] [RQ4] [RQ5]
      digit_carry_ff <= sub_low[4]; // [RQ2] [RQ4] [RQ5]
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      zero_ff <= 1'b0;
    end else if (updates_zero) begin
      zero_ff <= (result == 8'h00); // [RQ13] [RQ4]
    end
  end

  // file write port: one-cycle strobe with address and data
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      file_we_ff <= 1'b0;
      file_waddr_ff <= '0;
      file_wdata_ff <= 8'h00;
    end else begin
      file_we_ff <= to_file; // [RQ6] [RQ3] [RQ12]
      file_waddr_ff <= file_addr_i;
      file_wdata_ff <= result;
    end
  end

  // operands outside 5..7 are ignored rather than aliased
  generate
    for (genvar p = 0; p < DIR_PORT_COUNT; p++) begin : g_dir
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          dir_ff[p] <= DIR_RESET;
        end else if (is_dir && dir_addr_ok && (dir_sel == DIR_SEL_PORT_A + 3'(p))) begin
          dir_ff[p] <= acc_ff; // [RQ10]
        end
      end
    end
  endgenerate

  // sleep: status and watchdog change in the same edge as sleep entry
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timeout_ff <= TIMEOUT_RESET;
      powerdown_ff <= POWERDOWN_RESET;
      sleep_ff <= 1'b0;
    end else if (is_sleep) begin
      timeout_ff <= 1'b1; // [RQ7]
      powerdown_ff <= 1'b0; // [RQ7]
      sleep_ff <= 1'b1; // [RQ8]
    end else if (wake_i) begin
      sleep_ff <= 1'b0;
    end
  end

  assign acc_o = acc_ff;
  assign carry_flag_o = carry_ff;
  assign digit_carry_flag_o = digit_carry_ff;
  assign zero_flag_o = zero_ff;
  assign timeout_status_flag_o = timeout_ff;
  assign powerdown_status_flag_o = powerdown_ff;
  assign file_we_o = file_we_ff;
  assign file_waddr_o = file_waddr_ff;
  assign file_wdata_o = file_wdata_ff;
  assign port_a_direction_o = dir_ff[0];
  assign port_b_direction_o = dir_ff[1];
  assign port_c_direction_o = dir_ff[2];
  assign sleep_o = sleep_ff;
  assign osc_halt_o = sleep_ff; // [RQ8]
endmodule
`default_nettype wire

// ### hdl/exec_ops_pkg.sv
// constants for the subtract, xor, swap, direction-load and sleep datapath
package exec_ops_pkg;
  localparam int DATA_W = 8;
  localparam int FILE_ADDR_W = 7;
  localparam int FILE_ADDR_MAX = 127;
  localparam int DIR_PORT_COUNT = 3;
  localparam logic [2:0] DIR_SEL_PORT_A = 3'h5;
  localparam logic [2:0] DIR_SEL_PORT_B = 3'h6;
  localparam logic [2:0] DIR_SEL_PORT_C = 3'h7;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] WDT_CLEAR = 8'h00;
  localparam logic [7:0] WDT_PRESCALE_CLEAR = 8'h00;
  localparam logic [7:0] WDT_RESET = 8'h00;
  localparam logic TIMEOUT_RESET = 1'b1;
  localparam logic POWERDOWN_RESET = 1'b1;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_LITERAL_MINUS_ACC = 4'h1,
    OP_REG_MINUS_ACC = 4'h2,
    OP_REG_MINUS_ACC_BORROW = 4'h3,
    OP_NIBBLE_SWAP = 4'h4,
    OP_DIRECTION_LOAD = 4'h5,
    OP_LITERAL_XOR = 4'h6,
    OP_REGISTER_XOR = 4'h7,
    OP_SLEEP = 4'h8
  } op_type;
endpackage

// ### hdl/watchdog_counter.sv
// watchdog counter with prescaler, cleared by sleep entry
`timescale 1ns/1ps
`default_nettype none
module watchdog_counter #(
  parameter int PRESCALE_W = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic clear_i,
  output logic [7:0] count_o,
  output logic [PRESCALE_W-1:0] prescale_o
);
  import exec_ops_pkg::*;
  logic [PRESCALE_W-1:0] prescale_ff;
  logic [7:0] count_ff;
  wire prescale_wrap = &prescale_ff;
  if (PRESCALE_W < 1 || PRESCALE_W > 8) begin : g_bad_width
    $error("prescaler width out of range");
  end
  always_ff @(posedge clk_i) begin
    if (srst_i || clear_i) begin
      prescale_ff <= PRESCALE_W'(WDT_PRESCALE_CLEAR);
      count_ff <= WDT_CLEAR;
    end else if (run_i) begin
      prescale_ff <= prescale_ff + PRESCALE_W'(1);
      if (prescale_wrap) begin
        count_ff <= count_ff + 8'h01;
      end
    end
  end
  assign count_o = count_ff;
  assign prescale_o = prescale_ff;
endmodule
`default_nettype wire

// ### test/exec_ops_checker.sv
// port assertions for the execution datapath
`timescale 1ns/1ps
`default_nettype none
module exec_ops_checker
  import exec_ops_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic exec_i,
  input wire exec_ops_pkg::op_type op_i,
  input wire logic [7:0] literal_i,
  input wire logic dest_i,
  input wire logic [7:0] file_data_i,
  input wire logic [7:0] acc_o,
  input wire logic carry_flag_o,
  input wire logic zero_flag_o,
  input wire logic timeout_status_flag_o,
  input wire logic powerdown_status_flag_o,
  input wire logic file_we_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic sleep_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire lsub = exec_i && op_i == OP_LITERAL_MINUS_ACC;
  wire rsub = exec_i && op_i == OP_REG_MINUS_ACC;
  wire bsub = exec_i && op_i == OP_REG_MINUS_ACC_BORROW && !dest_i;
  wire swap = exec_i && op_i == OP_NIBBLE_SWAP && !dest_i;
  wire rxor = exec_i && op_i == OP_REGISTER_XOR && !dest_i;
  wire slp = exec_i && op_i == OP_SLEEP && !sleep_o;
  wire lxor = exec_i && op_i == OP_LITERAL_XOR;
  a_lit_sub_value: assert property (lsub |=> acc_o == $past(literal_i) - $past(acc_o))
    else $error("lit sub value");
  a_lit_sub_carry: assert property (lsub |=> carry_flag_o ==
    ($past(acc_o) <= $past(literal_i))) else $error("lit sub carry");
  a_file_write: assert property (rsub && dest_i |=> file_we_o &&
    file_wdata_o == $past(file_data_i) - $past(acc_o)) else $error("sub write back");
  a_reg_sub_carry: assert property (rsub |=> carry_flag_o ==
    ($past(acc_o) <= $past(file_data_i))) else $error("reg sub carry");
  a_borrow_value: assert property (bsub |=> acc_o == $past(file_data_i) -
    $past(acc_o) - {7'h00, !$past(carry_flag_o)}) else $error("borrow value");
  a_swap_flags: assert property (swap |=> $stable({carry_flag_o, zero_flag_o}) &&
    acc_o == {$past(file_data_i[3:0]), $past(file_data_i[7:4])}) else $error("swap");
  a_xor_acc_only: assert property (rxor |=> !file_we_o &&
    zero_flag_o == ($past(acc_o) == $past(file_data_i))) else $error("reg xor");
  a_sleep_status: assert property (slp |=> timeout_status_flag_o &&
    !powerdown_status_flag_o) else $error("sleep status");
  a_sleep_halt: assert property (slp |=> $rose(sleep_o)) else $error("sleep entry");
  a_lit_xor_value: assert property (lxor |=> acc_o == ($past(acc_o) ^ $past(literal_i)) &&
    $stable(carry_flag_o)) else $error("lit xor");
  c_borrow: cover property (bsub && !carry_flag_o);
  c_sleep: cover property (slp);
  c_file_write: cover property (rsub && dest_i);
endmodule
bind exec_ops exec_ops_checker i_chk (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .exec_i(exec_i),
  .op_i(op_i),
  .literal_i(literal_i),
  .dest_i(dest_i),
  .file_data_i(file_data_i),
  .acc_o(acc_o),
  .carry_flag_o(carry_flag_o),
  .zero_flag_o(zero_flag_o),
  .timeout_status_flag_o(timeout_status_flag_o),
  .powerdown_status_flag_o(powerdown_status_flag_o),
  .file_we_o(file_we_o),
  .file_wdata_o(file_wdata_o),
  .sleep_o(sleep_o)
);
`default_nettype wire

// ### test/subtract_xor_swap_sleep_ops_tb_top.sv
// self-checking bench for the execution datapath
`timescale 1ns/1ps
`default_nettype none
module subtract_xor_swap_sleep_ops_tb_top;
  import exec_ops_pkg::*;
  logic clk_i = 1'b0, srst_i = 1'b1, exec_i = 1'b0, dest_i = 1'b0, wake_i = 1'b0;
  op_type op_i = OP_NONE;
  logic [7:0] literal_i = 8'h00, file_data_i = 8'h00, acc_o, file_wdata_o, watchdog_counter_o;
  logic [7:0] port_a_direction_o, port_b_direction_o, port_c_direction_o;
  logic [6:0] file_addr_i = 7'h00, file_waddr_o;
  logic carry_flag_o, digit_carry_flag_o, zero_flag_o, file_we_o, sleep_o, osc_halt_o;
  logic timeout_status_flag_o, powerdown_status_flag_o;
  int n_mismatch = 0, compares = 0, cyc = 0;
  // one-bit prescaler lets the watchdog move within a short run
  exec_ops #(.WDT_PRESCALE_W(1)) i_dut (.*);
  always #50 clk_i = ~clk_i;
  task automatic ck(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one idle edge between ops, so exec_i never changes twice in a step
  task automatic run(op_type t, logic [7:0] k, logic d, logic [7:0] e, logic [2:0] f);
    @(posedge clk_i) #1 op_i = t;
    literal_i = k;
    file_data_i = k;
    file_addr_i = k[6:0];
    dest_i = d;
    exec_i = 1'b1;
    @(posedge clk_i) #1 exec_i = 1'b0;
    ck("result", e, d ? file_wdata_o : acc_o);
    ck("write", {7'h00, d}, {7'h00, file_we_o});
    if (d) begin
      ck("waddr", {1'b0, k[6:0]}, {1'b0, file_waddr_o});
    end
    ck("flags", {5'h00, f}, {5'h00, carry_flag_o, digit_carry_flag_o, zero_flag_o});
  endtask
  // reset held four edges; used at the start and again at the end of the run
  task automatic t_reset();
    srst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 srst_i = 1'b0;
    ck("acc_rst", ACC_RESET, acc_o);
    ck("flags_rst", 8'h00, {5'h00, carry_flag_o, digit_carry_flag_o, zero_flag_o});
    ck("status_rst", {6'h00, TIMEOUT_RESET, POWERDOWN_RESET},
      {6'h00, timeout_status_flag_o, powerdown_status_flag_o});
    ck("dir_a_rst", DIR_RESET, port_a_direction_o);
    ck("dir_b_rst", DIR_RESET, port_b_direction_o);
    ck("dir_c_rst", DIR_RESET, port_c_direction_o);
    ck("idle_rst", 8'h00, {5'h00, file_we_o, sleep_o, osc_halt_o});
    ck("wdt_rst", WDT_RESET, watchdog_counter_o);
    // zero result of a subtract: carry, digit carry and zero all set
    run(OP_LITERAL_MINUS_ACC, 8'h00, 1'b0, 8'h00, 3'b111);
    $display("reset test done");
  endtask
  task automatic t_subtract();
    run(OP_LITERAL_MINUS_ACC, 8'h05, 1'b0, 8'h05, 3'b110);
    run(OP_LITERAL_MINUS_ACC, 8'h03, 1'b0, 8'hFE, 3'b000);
    run(OP_REG_MINUS_ACC, 8'h05, 1'b1, 8'h07, 3'b000);
    run(OP_REG_MINUS_ACC, 8'hFF, 1'b0, 8'h01, 3'b110);
    run(OP_REG_MINUS_ACC_BORROW, 8'h00, 1'b0, 8'hFF, 3'b000);
    run(OP_REG_MINUS_ACC_BORROW, 8'h10, 1'b1, 8'h10, 3'b000);
    $display("subtract test done");
  endtask
  task automatic t_swap_xor();
    run(OP_REGISTER_XOR, 8'hFF, 1'b0, 8'h00, 3'b001);
    run(OP_NIBBLE_SWAP, 8'hA5, 1'b0, 8'h5A, 3'b001);
    run(OP_NIBBLE_SWAP, 8'h3C, 1'b1, 8'hC3, 3'b001);
    run(OP_REGISTER_XOR, 8'h5B, 1'b1, 8'h01, 3'b000);
    $display("swap and xor test done");
  endtask
  task automatic t_dir_sleep();
    run(OP_DIRECTION_LOAD, 8'h05, 1'b0, 8'h5A, 3'b000);
    run(OP_LITERAL_XOR, 8'hFF, 1'b0, 8'hA5, 3'b000);
    run(OP_DIRECTION_LOAD, 8'h04, 1'b0, 8'hA5, 3'b000);
    // operand 4 must not alias onto any port
    ck("dir_b_idle", DIR_RESET, port_b_direction_o);
    ck("dir_c_idle", DIR_RESET, port_c_direction_o);
    run(OP_DIRECTION_LOAD, 8'h06, 1'b0, 8'hA5, 3'b000);
    run(OP_DIRECTION_LOAD, 8'h07, 1'b0, 8'hA5, 3'b000);
    ck("dir_a", 8'h5A, port_a_direction_o);
    ck("dir_b", 8'hA5, port_b_direction_o);
    ck("dir_c", 8'hA5, port_c_direction_o);
    run(OP_SLEEP, 8'h00, 1'b0, 8'hA5, 3'b000);
    ck("status", 8'h02, {6'h00, timeout_status_flag_o, powerdown_status_flag_o});
    ck("watchdog", 8'h00, watchdog_counter_o);
    #300;
    ck("halted", 8'h03, {6'h00, sleep_o, osc_halt_o});
    ck("frozen", 8'h00, watchdog_counter_o);
    @(posedge clk_i) #1 wake_i = 1'b1;
    @(posedge clk_i) #1 wake_i = 1'b0;
    ck("awake", 8'h00, {6'h00, sleep_o, osc_halt_o});
    // one-bit prescaler: one count per two edges once running again
    repeat (4) @(posedge clk_i);
    #1 ck("wdt_run", 8'h02, watchdog_counter_o);
    $display("direction and sleep test done");
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 500) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    t_reset();
    t_subtract();
    t_swap_xor();
    t_dir_sleep();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
